// ### design/clock_gate_pkg.sv
// Constants, types and register map of the bank-0 peripheral clock gating block
package clock_gate_pkg;

  // Register byte offsets
  localparam logic [11:0] RUN_GATE_OFFSET        = 12'h100;
  localparam logic [11:0] SLEEP_GATE_OFFSET      = 12'h110;
  localparam logic [11:0] DEEP_GATE_OFFSET       = 12'h120;
  localparam logic [11:0] CONFIG_OFFSET          = 12'h060;
  localparam logic [11:0] IRQ_STATUS_OFFSET      = 12'h050;
  localparam logic [11:0] IRQ_MASK_OFFSET        = 12'h054;

  // Field positions
  localparam int ADC_GATE_BIT      = 16;
  localparam int WDOG_GATE_BIT     = 3;
  localparam int SPEED_LSB         = 8;
  localparam int SPEED_MSB         = 9;
  localparam int AUTO_GATING_BIT   = 27;
  localparam int SLEEP_REQ_BIT     = 0;
  localparam int DEEP_REQ_BIT      = 1;
  localparam int FAULT_ADC_BIT     = 0;
  localparam int FAULT_WDOG_BIT    = 1;

  // Writable masks and reset values
  localparam logic [31:0] RUN_WRITE_MASK   = 32'h0001_0308;
  localparam logic [31:0] SLEEP_WRITE_MASK = 32'h0001_0308;
  localparam logic [31:0] DEEP_WRITE_MASK  = 32'h0001_0008;
  localparam logic [31:0] GATE_FIXED_ONES  = 32'h0000_0040;
  localparam logic [31:0] GATE_RESET       = 32'h0000_0040;
  localparam logic [31:0] CONFIG_MASK      = 32'h0800_0003;
  localparam logic [31:0] IRQ_MASK_BITS    = 32'h0000_0003;

  // Converter speed codes
  localparam logic [1:0] SPEED_125K = 2'h0;
  localparam logic [1:0] SPEED_250K = 2'h1;
  localparam logic [1:0] SPEED_MAX  = 2'h1;

  // Power mode of the processor
  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP} power_mode_type;

  // Peripheral clock enables and sample speed
  typedef struct packed {
    logic       adc_clock_en;
    logic       watchdog_clock_en;
    logic [1:0] sample_speed;
  } gate_out_type;

  // Peripheral access probe from the system bus fabric
  typedef struct packed {
    logic adc_access;
    logic watchdog_access;
  } access_type;

endpackage

// ### design/clock_gate_bank0.sv
// AHB-Lite slave holding the bank-0 run, sleep and deep-sleep clock gating registers
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module clock_gate_bank0
  import clock_gate_pkg::*;
(
  input  wire logic         i_clock,      // System clock, 250 MHz
  input  wire logic         i_srst,       // Synchronous reset, active high
  input  wire logic         i_hsel,       // Slave select
  input  wire logic [31:0]  i_haddr,      // Byte address
  input  wire logic [1:0]   i_htrans,     // Transfer type
  input  wire logic         i_hwrite,     // Write when high
  input  wire logic [2:0]   i_hsize,      // Transfer size
  input  wire logic [31:0]  i_hwdata,     // Write data
  input  wire logic         i_hready,     // Bus ready in
  input  wire access_type   i_access,     // Peripheral access attempts, one-cycle pulses
  output logic [31:0]       o_hrdata,     // Read data
  output logic              o_hreadyout,  // Slave ready
  output logic              o_hresp,      // Response, always OKAY
  output gate_out_type      o_gate,       // Effective clock enables and speed
  output access_type        o_bus_fault,  // Fault on ungated access, one-cycle pulses
  output logic              o_irq         // Level interrupt
);

  logic [31:0]    run_gate_reg;
  logic [31:0]    sleep_gate_reg;
  logic [31:0]    deep_gate_reg;
  logic [31:0]    config_reg;
  logic [31:0]    irq_status_reg;
  logic [31:0]    irq_mask_reg;
  logic           wr_pend_reg;
  logic [11:0]    wr_addr_reg;
  logic [31:0]    rdata_next;
  logic [31:0]    active_gate;
  logic [1:0]     speed_field;
  logic           take;
  logic [1:0]     fault_event;
  power_mode_type mode;
  logic           hit_run;
  logic           hit_sleep;
  logic           hit_deep;
  logic           hit_config;
  logic           hit_status;
  logic           hit_mask;
  logic [31:0]    run_gate_view;
  logic [31:0]    sleep_gate_view;
  logic [31:0]    deep_gate_view;
  logic [31:0]    config_view;
  logic [31:0]    irq_mask_view;
  logic [31:0]    irq_status_next;
  logic [31:0]    fault_word;
  logic           irq_pending;

  // Clamp a speed code to the highest permitted rate
  function automatic logic [1:0] clamp_speed(input logic [1:0] code);
    clamp_speed = (code > SPEED_MAX) ? SPEED_MAX : code;
  endfunction

  // Write strobe of one register: a write data phase whose address matches
  function automatic logic write_hit(input logic pend, input logic [11:0] addr, input logic [11:0] offset);
    write_hit = pend && (addr == offset);
  endfunction

  // Gating register after a write: writable gates from the data, fixed ones forced
  function automatic logic [31:0] gate_merge(input logic [31:0] data, input logic [31:0] mask);
    gate_merge = (data & mask) | GATE_FIXED_ONES;
  endfunction

  // Plain register after a write: only the implemented bits are kept
  function automatic logic [31:0] field_merge(input logic [31:0] data, input logic [31:0] mask);
    field_merge = data & mask;
  endfunction

  // Address phase accepted
  assign take = i_hsel && i_hready && i_htrans[1];

  // Write strobes, one per register, high in the data phase of a write that hits it
  assign hit_run    = write_hit(wr_pend_reg, wr_addr_reg, RUN_GATE_OFFSET);
  assign hit_sleep  = write_hit(wr_pend_reg, wr_addr_reg, SLEEP_GATE_OFFSET);
  assign hit_deep   = write_hit(wr_pend_reg, wr_addr_reg, DEEP_GATE_OFFSET);
  assign hit_config = write_hit(wr_pend_reg, wr_addr_reg, CONFIG_OFFSET);
  assign hit_status = write_hit(wr_pend_reg, wr_addr_reg, IRQ_STATUS_OFFSET);
  assign hit_mask   = write_hit(wr_pend_reg, wr_addr_reg, IRQ_MASK_OFFSET);

  // Write data phase flag: registers update when the data are on the bus
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      wr_pend_reg <= 1'b0;
    else
      wr_pend_reg <= take && i_hwrite;
  end

  // Address of the transfer whose data phase follows
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      wr_addr_reg <= '0;
    else if (take)
      wr_addr_reg <= i_haddr[11:0];
  end

  // Run gating register, writable gates and speed field
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      run_gate_reg <= GATE_RESET;
    else if (hit_run)
      run_gate_reg <= gate_merge(i_hwdata, RUN_WRITE_MASK);
  end

  // Sleep gating register, bits 7, 5:4, 2:0 stay zero
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      sleep_gate_reg <= GATE_RESET;
    else if (hit_sleep)
      sleep_gate_reg <= gate_merge(i_hwdata, SLEEP_WRITE_MASK);
  end

  // Deep-sleep gating register, only converter and watchdog gates writable
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      deep_gate_reg <= GATE_RESET;
    else if (hit_deep)
      deep_gate_reg <= gate_merge(i_hwdata, DEEP_WRITE_MASK);
  end

  // Clock configuration: auto gating select and power mode requests
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      config_reg <= 32'h0000_0000;
    else if (hit_config)
      config_reg <= field_merge(i_hwdata, CONFIG_MASK);
  end

  // Interrupt mask
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      irq_mask_reg <= 32'h0000_0000;
    else if (hit_mask)
      irq_mask_reg <= field_merge(i_hwdata, IRQ_MASK_BITS);
  end

  // Current power mode from software request bits
  always_comb
  begin
    if (config_reg[DEEP_REQ_BIT])
      mode = MODE_DEEP;
    else if (config_reg[SLEEP_REQ_BIT])
      mode = MODE_SLEEP;
    else
      mode = MODE_RUN;
  end

  // Select the governing register for the mode
  always_comb
  begin
    case (mode)
      MODE_SLEEP:
        active_gate = config_reg[AUTO_GATING_BIT] ? sleep_gate_reg : run_gate_reg;
      MODE_DEEP:
        active_gate = config_reg[AUTO_GATING_BIT] ? deep_gate_reg : run_gate_reg;
      default:
        active_gate = run_gate_reg;
    endcase
  end

  // Speed field: deep-sleep register carries none, so it keeps the run field
  always_comb
  begin
    if (mode == MODE_SLEEP && config_reg[AUTO_GATING_BIT])
      speed_field = sleep_gate_reg[SPEED_MSB:SPEED_LSB];
    else
      speed_field = run_gate_reg[SPEED_MSB:SPEED_LSB];
  end

  // Registered clock enables and clamped speed
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_gate <= '0;
    else
    begin
      o_gate.adc_clock_en      <= active_gate[ADC_GATE_BIT];
      o_gate.watchdog_clock_en <= active_gate[WDOG_GATE_BIT];
      o_gate.sample_speed      <= clamp_speed(speed_field);
    end
  end

  // Fault on access to an unclocked unit
  assign fault_event[FAULT_ADC_BIT]  = i_access.adc_access && !o_gate.adc_clock_en;
  assign fault_event[FAULT_WDOG_BIT] = i_access.watchdog_access && !o_gate.watchdog_clock_en;

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_bus_fault <= '0;
    else
    begin
      o_bus_fault.adc_access      <= fault_event[FAULT_ADC_BIT];
      o_bus_fault.watchdog_access <= fault_event[FAULT_WDOG_BIT];
    end
  end

  // Fault events widened to the status word
  assign fault_word = 32'(fault_event);

  // Next status: ones written clear, new events set, an event wins over its clear
  always_comb
  begin
    irq_status_next = irq_status_reg | fault_word;
    if (hit_status)
      irq_status_next = (irq_status_reg & ~i_hwdata) | fault_word;
    irq_status_next = irq_status_next & IRQ_MASK_BITS;
  end

  // Sticky fault status
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      irq_status_reg <= '0;
    else
      irq_status_reg <= irq_status_next;
  end

  // Any unmasked status bit pending
  assign irq_pending = |(irq_status_reg & irq_mask_reg);

  // Interrupt level, one cycle behind the status
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_irq <= 1'b0;
    else
      o_irq <= irq_pending;
  end

  // Values as they stand once a pending write lands, so a read right behind a write sees it
  assign run_gate_view   = hit_run    ? gate_merge(i_hwdata, RUN_WRITE_MASK)   : run_gate_reg;
  assign sleep_gate_view = hit_sleep  ? gate_merge(i_hwdata, SLEEP_WRITE_MASK) : sleep_gate_reg;
  assign deep_gate_view  = hit_deep   ? gate_merge(i_hwdata, DEEP_WRITE_MASK)  : deep_gate_reg;
  assign config_view     = hit_config ? field_merge(i_hwdata, CONFIG_MASK)     : config_reg;
  assign irq_mask_view   = hit_mask   ? field_merge(i_hwdata, IRQ_MASK_BITS)   : irq_mask_reg;

  // Read mux, unmapped addresses read zero
  always_comb
  begin
    case (i_haddr[11:0])
      RUN_GATE_OFFSET:   rdata_next = run_gate_view;
      SLEEP_GATE_OFFSET: rdata_next = sleep_gate_view;
      DEEP_GATE_OFFSET:  rdata_next = deep_gate_view;
      CONFIG_OFFSET:     rdata_next = config_view;
      IRQ_STATUS_OFFSET: rdata_next = irq_status_next;
      IRQ_MASK_OFFSET:   rdata_next = irq_mask_view;
      default:           rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data registered for the data phase
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_hrdata <= 32'h0000_0000;
    else if (take && !i_hwrite)
      o_hrdata <= rdata_next;
  end

  // Zero wait states, OKAY always
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // Elaboration checks: the field layout must suit the logic above
  if (SPEED_MSB != SPEED_LSB + 1)
  begin : g_speed_width
    $error("speed field must be two bits");
  end
  if (FAULT_ADC_BIT >= $bits(fault_event) || FAULT_WDOG_BIT >= $bits(fault_event) ||
      FAULT_ADC_BIT == FAULT_WDOG_BIT)
  begin : g_fault_bits
    $error("fault bits must fill the low end of the status word");
  end
  if ((GATE_FIXED_ONES & (RUN_WRITE_MASK | SLEEP_WRITE_MASK | DEEP_WRITE_MASK)) != '0)
  begin : g_fixed_ones
    $error("fixed one bits must not be writable");
  end
  if (!RUN_WRITE_MASK[ADC_GATE_BIT] || !RUN_WRITE_MASK[WDOG_GATE_BIT] ||
      !SLEEP_WRITE_MASK[ADC_GATE_BIT] || !SLEEP_WRITE_MASK[WDOG_GATE_BIT] ||
      !DEEP_WRITE_MASK[ADC_GATE_BIT] || !DEEP_WRITE_MASK[WDOG_GATE_BIT])
  begin : g_gate_bits
    $error("every gate bit must be writable");
  end
  if (!CONFIG_MASK[AUTO_GATING_BIT] || !CONFIG_MASK[SLEEP_REQ_BIT] || !CONFIG_MASK[DEEP_REQ_BIT])
  begin : g_config_bits
    $error("configuration control bits must be writable");
  end
  if (!IRQ_MASK_BITS[FAULT_ADC_BIT] || !IRQ_MASK_BITS[FAULT_WDOG_BIT])
  begin : g_status_bits
    $error("every fault needs a status bit");
  end
  if (SPEED_MAX != SPEED_250K)
  begin : g_speed_max
    $error("fastest permitted speed code must be the 250k code");
  end

endmodule

// ### tb/clock_gate_bank0_chk.sv
// Port checker for the bank-0 clock gating block
`timescale 1ns/1ps
module clock_gate_bank0_chk
  import clock_gate_pkg::*;
(
  input wire logic         i_clock,      // Clock
  input wire logic         i_srst,       // Reset
  input wire logic         i_hsel,       // Select
  input wire logic [1:0]   i_htrans,     // Transfer type
  input wire logic         i_hwrite,     // Write
  input wire logic         i_hready,     // Ready in
  input wire access_type   i_access,     // Access pulses
  input wire logic [31:0]  o_hrdata,     // Read data
  input wire logic         o_hreadyout,  // Ready out
  input wire logic         o_hresp,      // Response
  input wire gate_out_type o_gate,       // Enables
  input wire access_type   o_bus_fault,  // Faults
  input wire logic         o_irq         // Interrupt
);
  logic rd_take;
  logic wr_dp_reg;
  // Read address phase taken this cycle
  assign rd_take = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
  // High during a write data phase
  always_ff @(posedge i_clock)
    wr_dp_reg <= !i_srst && i_hsel && i_hready && i_htrans[1] && i_hwrite;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  a_adc_fault_cause: assert property (!$past(i_srst) |->
    o_bus_fault.adc_access == ($past(i_access.adc_access) && !$past(o_gate.adc_clock_en))) else $error("adc fault");
  a_wdog_fault_cause: assert property (i_access.watchdog_access && !o_gate.watchdog_clock_en |=>
    o_bus_fault.watchdog_access) else $error("watchdog fault missing");
  a_speed_clamped: assert property (o_gate.sample_speed <= SPEED_MAX) else $error("speed too high");
  a_gate_after_write: assert property (!$stable(o_gate) |-> $past(wr_dp_reg, 2)) else $error("gate moved");
  a_reset_clears: assert property ($past(i_srst) |-> o_gate == 4'h0 && o_bus_fault == 2'h0 && !o_irq)
    else $error("not cleared by reset");
  a_read_data_holds: assert property (!$past(rd_take) && !$past(i_srst) |-> $stable(o_hrdata))
    else $error("read data moved");
  a_irq_has_cause: assert property ($rose(o_irq) |-> $past(o_bus_fault != 2'h0) || $past(wr_dp_reg, 2))
    else $error("irq without cause");
  a_bus_always_okay: assert property (o_hreadyout && !o_hresp) else $error("bus not okay");
endmodule
bind clock_gate_bank0 clock_gate_bank0_chk u_chk (.i_clock, .i_srst, .i_hsel, .i_htrans, .i_hwrite, .i_hready,
  .i_access, .o_hrdata, .o_hreadyout, .o_hresp, .o_gate, .o_bus_fault, .o_irq);

// ### tb/clock_gate_bank0_tb.sv
// Self-checking bench for the bank-0 clock gating block
`timescale 1ns/1ps
module clock_gate_bank0_tb;
  import clock_gate_pkg::*;
  logic         i_clock, i_srst, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp, o_irq;
  logic [31:0]  i_haddr, i_hwdata, o_hrdata, rd;
  logic [1:0]   i_htrans;
  logic [2:0]   i_hsize;
  access_type   i_access, o_bus_fault;
  gate_out_type o_gate;
  int           failures, cmp_count;
  assign i_hready = o_hreadyout;
  clock_gate_bank0 dut (.i_clock, .i_srst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
    .i_hready, .i_access, .o_hrdata, .o_hreadyout, .o_hresp, .o_gate, .o_bus_fault, .o_irq);
  // Clock, 4 ns period
  initial
  begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One single AHB-Lite transfer; read data lands in rd
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    i_haddr  <= {20'h0_0000, a};
    i_hwrite <= wr;
    i_htrans <= 2'h2;
    do @(posedge i_clock); while (i_hready !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clock); while (i_hready !== 1'b1);
    rd = o_hrdata;
  endtask
  // One-cycle access pulse, then the fault pulse is compared
  task automatic poke(input access_type a, input access_type exp);
    i_access <= a;
    @(posedge i_clock);
    i_access <= 2'h0;
    @(posedge i_clock);
    chk("fault", {30'h0, exp}, {30'h0, o_bus_fault});
  endtask
  task automatic gchk(input logic [3:0] exp);
    repeat (2) @(posedge i_clock);
    chk("gate", {28'h0, exp}, {28'h0, o_gate});
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog against a hung run
  initial
  begin
    repeat (5000) @(posedge i_clock);
    failures++;
    summarize();
  end
  // Main test sequence
  initial
  begin
    i_srst = 1'b1;
    i_hsel = 1'b1;
    i_haddr = 32'h0;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hsize = 3'h2;
    i_hwdata = 32'h0;
    i_access = 2'h0;
    repeat (6) @(posedge i_clock);
    i_srst <= 1'b0;
    @(posedge i_clock);
    xfer(1'b0, RUN_GATE_OFFSET, 32'h0);
    chk("run", 32'h0000_0040, rd);
    xfer(1'b0, SLEEP_GATE_OFFSET, 32'h0);
    chk("sleep", 32'h0000_0040, rd);
    xfer(1'b0, DEEP_GATE_OFFSET, 32'h0);
    chk("deep", 32'h0000_0040, rd);
    chk("gate", 32'h0, {28'h0, o_gate});
    $display("test reset values done");
    xfer(1'b1, DEEP_GATE_OFFSET, 32'hFFFF_FFFF);
    xfer(1'b0, DEEP_GATE_OFFSET, 32'h0);
    chk("deep", 32'h0001_0048, rd);
    xfer(1'b1, SLEEP_GATE_OFFSET, 32'hFFFF_FFFF);
    xfer(1'b0, SLEEP_GATE_OFFSET, 32'h0);
    chk("sleep", 32'h0001_0348, rd);
    xfer(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    xfer(1'b0, 12'h0FC, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test access kinds done");
    xfer(1'b1, RUN_GATE_OFFSET, 32'h0001_0308);
    gchk(4'hD);
    xfer(1'b1, RUN_GATE_OFFSET, 32'h0001_0108);
    gchk(4'hD);
    xfer(1'b1, RUN_GATE_OFFSET, 32'h0001_0008);
    gchk(4'hC);
    $display("test run gating done");
    xfer(1'b1, RUN_GATE_OFFSET, 32'h0);
    gchk(4'h0);
    poke(2'h3, 2'h3);
    @(posedge i_clock);
    chk("irq masked", 32'h0, {31'h0, o_irq});
    xfer(1'b0, IRQ_STATUS_OFFSET, 32'h0);
    chk("status", 32'h3, rd);
    xfer(1'b1, IRQ_MASK_OFFSET, 32'h3);
    repeat (2) @(posedge i_clock);
    chk("irq", 32'h1, {31'h0, o_irq});
    xfer(1'b1, IRQ_STATUS_OFFSET, 32'h3);
    repeat (2) @(posedge i_clock);
    chk("irq cleared", 32'h0, {31'h0, o_irq});
    $display("test faults done");
    xfer(1'b1, SLEEP_GATE_OFFSET, 32'h0000_0008);
    xfer(1'b1, CONFIG_OFFSET, 32'h0800_0001);
    gchk(4'h4);
    xfer(1'b1, CONFIG_OFFSET, 32'h0000_0001);
    gchk(4'h0);
    xfer(1'b1, CONFIG_OFFSET, 32'h0800_0002);
    gchk(4'hC);
    poke(2'h3, 2'h0);
    xfer(1'b0, DEEP_GATE_OFFSET, 32'h0);
    xfer(1'b1, DEEP_GATE_OFFSET, rd & ~32'h0001_0000);
    gchk(4'h4);
    poke(2'h3, 2'h2);
    $display("test power modes done");
    summarize();
  end
endmodule
